//--- core/pifb_top.sv
// peripheral interrupt flag bank with axi4-lite register access
`timescale 1ns/10ps
`include "pifb_defs.svh"
module pifb_top #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic osc_fail_evt,
  input wire logic clock_switch_evt,
  input wire logic clock_tuning_evt,
  input wire logic mem_scanner_evt,
  input wire logic checksum_evt,
  input wire logic nonvol_op_done_evt,
  input wire logic [1:0] capcmp_capture,
  input wire logic [1:0] capcmp_match,
  input wire logic [1:0] capcmp_out,
  input wire logic [2:0] period_timer_evt,
  input wire logic gated_timer_b_evt,
  input wire logic gated_timer_b_gate,
  input wire logic [3:0] pulse_param_evt,
  input wire logic [3:0] pulse_period_evt,
  input wire logic [5:0] logic_cell_evt,
  input wire logic serial_a_rx_flag,
  input wire logic serial_a_tx_flag
);
  // ----------------------------------------
  // local state
  // ----------------------------------------
  typedef struct packed {
    pifb_pkg::pifb_cc_mode_t mode_a; // unit a mode
    pifb_pkg::pifb_cc_mode_t mode_b; // unit b mode
    logic [1:0] out_q; // last unit outputs
    logic gate_q; // last gate level
  } pifb_top_st_t;
  pifb_top_st_t s;
  pifb_top_st_t next_s;

  pifb_regbus_if rb();

  logic [7:0] sys_flags; // system events register
  logic [7:0] tc_flags; // timer and capture register
  logic [7:0] pw_flags; // pulse width register
  logic [7:0] sl_flags; // serial and logic cell register
  logic [7:0] sys_set;
  logic [7:0] tc_set;
  logic [7:0] pw_set;
  logic [7:0] sl_set;
  logic [7:0] sl_ro;
  logic [1:0] trail; // falling edge of unit outputs
  logic gate_fall; // gate went inactive

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // picks the event that counts in the unit's mode
  function automatic logic cc_set(input pifb_pkg::pifb_cc_mode_t m, input logic cap,
                                  input logic match, input logic tr);
    case (m)
      pifb_pkg::pifb_cc_capture: cc_set = cap;
      pifb_pkg::pifb_cc_compare: cc_set = match;
      pifb_pkg::pifb_cc_pwm: cc_set = tr;
      default: cc_set = 1'b0;
    endcase
  endfunction : cc_set

  // true for indices that hold a register
  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == `PIFB_IDX_SYS) || (idx == `PIFB_IDX_TC) || (idx == `PIFB_IDX_PW)
          || (idx == `PIFB_IDX_SL) || (idx == `PIFB_IDX_CTRL);
  endfunction : mapped

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  pifb_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .rb(rb)
  );

  // ----------------------------------------
  // event routing
  // ----------------------------------------
  // events come from same-clock peripherals, so no synchroniser;
  // no enable gates any set path, enables live elsewhere
  always_comb begin
    trail = s.out_q & ~capcmp_out;
    gate_fall = s.gate_q & ~gated_timer_b_gate;
    sys_set = 8'h00;
    sys_set[`PIFB_BIT_OSC] = osc_fail_evt;
    sys_set[`PIFB_BIT_CSW] = clock_switch_evt;
    sys_set[`PIFB_BIT_TUNE] = clock_tuning_evt;
    sys_set[`PIFB_BIT_SCAN] = mem_scanner_evt;
    sys_set[`PIFB_BIT_CRC] = checksum_evt;
    sys_set[`PIFB_BIT_NVM] = nonvol_op_done_evt;
    tc_set = 8'h00;
    // mode picks capture, match or trailing edge
    tc_set[`PIFB_BIT_CC_A] = cc_set(s.mode_a, capcmp_capture[0], capcmp_match[0], trail[0]);
    tc_set[`PIFB_BIT_CC_B] = cc_set(s.mode_b, capcmp_capture[1], capcmp_match[1], trail[1]);
    tc_set[`PIFB_BIT_PT_A] = period_timer_evt[0];
    tc_set[`PIFB_BIT_PT_B] = period_timer_evt[1];
    tc_set[`PIFB_BIT_PT_C] = period_timer_evt[2];
    tc_set[`PIFB_BIT_GATE] = gate_fall;
    tc_set[`PIFB_BIT_GTMR] = gated_timer_b_evt;
    // units interleave: parameter odd, period even
    for (int i = 0; i < 4; i++) begin
      pw_set[2*i+1] = pulse_param_evt[i];
      pw_set[2*i] = pulse_period_evt[i];
    end
    sl_set = {2'b00, logic_cell_evt};
    // serial flags mirror the buffer levels; the serial unit clears them
    sl_ro = 8'h00;
    sl_ro[`PIFB_BIT_RX] = serial_a_rx_flag;
    sl_ro[`PIFB_BIT_TX] = serial_a_tx_flag;
  end

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  // masks keep unused bits at zero and ignore writes there
  pifb_flag_reg #(
    .W(8),
    .WR_MASK(`PIFB_MASK_SYS),
    .RO_MASK(`PIFB_MASK_NONE)
  ) u_sys (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(rb.wr_en && rb.wr_idx == `PIFB_IDX_SYS),
    .wr_data(rb.wr_data),
    .set(sys_set),
    .ro_level(8'h00),
    .flags(sys_flags)
  );
  pifb_flag_reg #(
    .W(8),
    .WR_MASK(`PIFB_MASK_TC),
    .RO_MASK(`PIFB_MASK_NONE)
  ) u_tc (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(rb.wr_en && rb.wr_idx == `PIFB_IDX_TC),
    .wr_data(rb.wr_data),
    .set(tc_set),
    .ro_level(8'h00),
    .flags(tc_flags)
  );
  pifb_flag_reg #(
    .W(8),
    .WR_MASK(`PIFB_MASK_PW),
    .RO_MASK(`PIFB_MASK_NONE)
  ) u_pw (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(rb.wr_en && rb.wr_idx == `PIFB_IDX_PW),
    .wr_data(rb.wr_data),
    .set(pw_set),
    .ro_level(8'h00),
    .flags(pw_flags)
  );
  pifb_flag_reg #(
    .W(8),
    .WR_MASK(`PIFB_MASK_SL_WR),
    .RO_MASK(`PIFB_MASK_SL_RO)
  ) u_sl (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(rb.wr_en && rb.wr_idx == `PIFB_IDX_SL),
    .wr_data(rb.wr_data),
    .set(sl_set),
    .ro_level(sl_ro),
    .flags(sl_flags)
  );

  // ----------------------------------------
  // read mux and decode
  // ----------------------------------------
  // read data is taken by the slave at the address handshake
  always_comb begin
    rb.wr_hit = mapped(rb.wr_idx);
    rb.rd_hit = mapped(rb.rd_idx);
    case (rb.rd_idx)
      `PIFB_IDX_SYS: rb.rd_data = sys_flags;
      `PIFB_IDX_TC: rb.rd_data = tc_flags;
      `PIFB_IDX_PW: rb.rd_data = pw_flags;
      `PIFB_IDX_SL: rb.rd_data = sl_flags;
      `PIFB_IDX_CTRL: rb.rd_data = {4'h0, s.mode_b, s.mode_a};
      default: rb.rd_data = 8'h00; // unmapped reads zero with an error answer
    endcase
  end

  // ----------------------------------------
  // mode control and edge history
  // ----------------------------------------
  // a mode change applies from the next cycle; pending flags stay
  always_comb begin
    next_s = s;
    next_s.out_q = capcmp_out;
    next_s.gate_q = gated_timer_b_gate;
    if (rb.wr_en && rb.wr_idx == `PIFB_IDX_CTRL) begin
      next_s.mode_a = pifb_pkg::pifb_cc_mode_t'(rb.wr_data[`PIFB_CTRL_A_LSB +: 2]);
      next_s.mode_b = pifb_pkg::pifb_cc_mode_t'(rb.wr_data[`PIFB_CTRL_B_LSB +: 2]);
    end
  end
  // state register; edge history clears so no false edge after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= next_s;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic wr_sys;
  logic wr_tc;
  assign wr_sys = rb.wr_en && rb.wr_idx == `PIFB_IDX_SYS;
  assign wr_tc = rb.wr_en && rb.wr_idx == `PIFB_IDX_TC;

  // a unit output high then low while in pwm mode
  sequence s_trail_a;
    s.mode_a == pifb_pkg::pifb_cc_pwm && capcmp_out[0] ##1
      s.mode_a == pifb_pkg::pifb_cc_pwm && !capcmp_out[0];
  endsequence
  // the gate active then inactive
  sequence s_gate_off;
    gated_timer_b_gate ##1 !gated_timer_b_gate;
  endsequence

  property p_osc_set;
    @(posedge aclk) disable iff (!aresetn) osc_fail_evt |=> sys_flags[`PIFB_BIT_OSC];
  endproperty
  a_osc_set: assert property (p_osc_set) else $error("osc flag not set");

  property p_sys_hold;
    @(posedge aclk) disable iff (!aresetn)
      sys_flags[`PIFB_BIT_CSW] && !wr_sys |=> sys_flags[`PIFB_BIT_CSW];
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("switch flag lost");

  property p_nvm_set;
    @(posedge aclk) disable iff (!aresetn)
      nonvol_op_done_evt ##1 !wr_sys |=> sys_flags[`PIFB_BIT_NVM];
  endproperty
  a_nvm_set: assert property (p_nvm_set) else $error("nvm flag not held");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
      s.mode_a == pifb_pkg::pifb_cc_capture && capcmp_capture[0] |=> tc_flags[`PIFB_BIT_CC_A];
  endproperty
  a_capture: assert property (p_capture) else $error("capture flag not set");

  property p_compare;
    @(posedge aclk) disable iff (!aresetn)
      s.mode_b == pifb_pkg::pifb_cc_compare && capcmp_match[1] |=> tc_flags[`PIFB_BIT_CC_B];
  endproperty
  a_compare: assert property (p_compare) else $error("match flag not set");

  property p_trail;
    @(posedge aclk) disable iff (!aresetn) s_trail_a |=> tc_flags[`PIFB_BIT_CC_A];
  endproperty
  a_trail: assert property (p_trail) else $error("edge flag not set");

  property p_period;
    @(posedge aclk) disable iff (!aresetn) period_timer_evt[2] |=> tc_flags[`PIFB_BIT_PT_C];
  endproperty
  a_period: assert property (p_period) else $error("period timer flag");

  property p_gate;
    @(posedge aclk) disable iff (!aresetn) s_gate_off |=> tc_flags[`PIFB_BIT_GATE];
  endproperty
  a_gate: assert property (p_gate) else $error("gate flag not set");

  property p_gtmr;
    @(posedge aclk) disable iff (!aresetn) gated_timer_b_evt |=> tc_flags[`PIFB_BIT_GTMR];
  endproperty
  a_gtmr: assert property (p_gtmr) else $error("timer flag not set");

  property p_param;
    @(posedge aclk) disable iff (!aresetn) pulse_param_evt[3] |=> pw_flags[7];
  endproperty
  a_param: assert property (p_param) else $error("parameter flag");

  property p_per;
    @(posedge aclk) disable iff (!aresetn) pulse_period_evt[0] |=> pw_flags[0];
  endproperty
  a_per: assert property (p_per) else $error("period flag");

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
      wr_tc && !rb.wr_data[`PIFB_BIT_GTMR] && gated_timer_b_evt |=> tc_flags[`PIFB_BIT_GTMR];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr_sys && rb.wr_data == 8'h00 && sys_set == 8'h00 |=> sys_flags == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("zero write did not clear");

  property p_unused;
    @(posedge aclk) disable iff (!aresetn)
      sys_flags[7:6] == 2'b00 && tc_flags[7] == 1'b0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");

  property p_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> sys_flags == 8'h00 && tc_flags == 8'h00 && pw_flags == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("flags not cleared by reset");

  property p_bhold;
    @(posedge aclk) disable iff (!aresetn) bvalid && !bready |=> bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
endmodule : pifb_top

//--- core/pifb_defs.svh
// register indices, field positions, masks and reset values of the flag bank
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH
// register indices; the bus byte address is four times the index
`define PIFB_IDX_SYS 8'h8d
`define PIFB_IDX_TC 8'h8e
`define PIFB_IDX_PW 8'h8f
`define PIFB_IDX_SL 8'h90
`define PIFB_IDX_CTRL 8'h93
// reset values
`define PIFB_RST_FLAGS 8'h00
// implemented, writable and read-only bits
`define PIFB_MASK_SYS 8'h3f
`define PIFB_MASK_TC 8'h7f
`define PIFB_MASK_PW 8'hff
`define PIFB_MASK_SL_WR 8'h3f
`define PIFB_MASK_SL_RO 8'hc0
`define PIFB_MASK_NONE 8'h00
// field positions
`define PIFB_BIT_OSC 5
`define PIFB_BIT_CSW 4
`define PIFB_BIT_TUNE 3
`define PIFB_BIT_SCAN 2
`define PIFB_BIT_CRC 1
`define PIFB_BIT_NVM 0
`define PIFB_BIT_CC_B 6
`define PIFB_BIT_CC_A 5
`define PIFB_BIT_PT_C 4
`define PIFB_BIT_PT_B 3
`define PIFB_BIT_PT_A 2
`define PIFB_BIT_GATE 1
`define PIFB_BIT_GTMR 0
`define PIFB_BIT_RX 7
`define PIFB_BIT_TX 6
`define PIFB_CTRL_A_LSB 0
`define PIFB_CTRL_B_LSB 2
// bus answers
`define PIFB_RESP_OKAY 2'h0
`define PIFB_RESP_SLVERR 2'h2
`endif

//--- core/pifb_pkg.sv
// types shared by the flag bank modules
package pifb_pkg;
  // capture/compare unit operating mode
  typedef enum logic [1:0] {pifb_cc_off, pifb_cc_capture, pifb_cc_compare, pifb_cc_pwm} pifb_cc_mode_t;
  // bus channel state: waiting or answering
  typedef enum logic {pifb_idle, pifb_resp} pifb_ch_state_t;
endpackage : pifb_pkg

//--- core/pifb_regbus_if.sv
// internal register access carrier between bus slave and register file
`timescale 1ns/10ps
interface pifb_regbus_if;
  logic wr_en; // one-cycle write pulse
  logic [7:0] wr_idx; // write register index
  logic [7:0] wr_data; // write byte
  logic wr_hit; // write index is mapped
  logic [7:0] rd_idx; // read register index
  logic [7:0] rd_data; // read byte
  logic rd_hit; // read index is mapped
  modport bus (output wr_en, wr_idx, wr_data, rd_idx, input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_idx, wr_data, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface : pifb_regbus_if

//--- core/pifb_axil_slave.sv
// axi4-lite slave that turns bus transfers into register strobes
`timescale 1ns/10ps
`include "pifb_defs.svh"
module pifb_axil_slave #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  pifb_regbus_if.bus rb
);
  typedef struct packed {
    pifb_pkg::pifb_ch_state_t wst;
    pifb_pkg::pifb_ch_state_t rst;
    logic aw_got;
    logic w_got;
    logic [7:0] widx;
    logic [7:0] wbyte;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic wr_en;
    logic arready;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
  } pifb_axil_st_t;
  pifb_axil_st_t s;
  pifb_axil_st_t next_s;
  // address and data channels are taken independently, answer follows both
  always_comb begin
    next_s = s;
    next_s.wr_en = 1'b0;
    if (s.awready && awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.widx = awaddr[9:2];
    end
    if (s.wready && wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wbyte = wdata[7:0];
      next_s.wlane = wstrb[0];
    end
    case (s.wst)
      pifb_pkg::pifb_idle: if (s.aw_got && s.w_got) begin
        next_s.wst = pifb_pkg::pifb_resp;
        next_s.bvalid = 1'b1;
        next_s.bresp = rb.wr_hit ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
        // registers live in byte lane 0 only
        next_s.wr_en = rb.wr_hit && s.wlane;
      end
      pifb_pkg::pifb_resp: if (bready) begin
        next_s.wst = pifb_pkg::pifb_idle;
        next_s.bvalid = 1'b0;
        next_s.aw_got = 1'b0;
        next_s.w_got = 1'b0;
      end
      default: next_s.wst = pifb_pkg::pifb_idle;
    endcase
    next_s.awready = !next_s.aw_got;
    next_s.wready = !next_s.w_got;
    // read: data sampled at the address handshake
    case (s.rst)
      pifb_pkg::pifb_idle: if (arvalid && s.arready) begin
        next_s.rst = pifb_pkg::pifb_resp;
        next_s.arready = 1'b0;
        next_s.rvalid = 1'b1;
        next_s.rbyte = rb.rd_data;
        next_s.rresp = rb.rd_hit ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
      end else begin
        next_s.arready = 1'b1;
      end
      pifb_pkg::pifb_resp: if (rready) begin
        next_s.rst = pifb_pkg::pifb_idle;
        next_s.rvalid = 1'b0;
        next_s.arready = 1'b1;
      end
      default: next_s.rst = pifb_pkg::pifb_idle;
    endcase
  end
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= next_s;
  end
  assign rb.wr_en = s.wr_en;
  assign rb.wr_idx = s.widx;
  assign rb.wr_data = s.wbyte;
  assign rb.rd_idx = araddr[9:2];
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = {24'h000000, s.rbyte};
  assign rresp = s.rresp;
endmodule : pifb_axil_slave

//--- core/pifb_flag_reg.sv
// one flag register: hardware sets, software writes, read-only levels
`timescale 1ns/10ps
`include "pifb_defs.svh"
module pifb_flag_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] WR_MASK = {W{1'b1}},
  parameter logic [W-1:0] RO_MASK = {W{1'b0}}
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] ro_level,
  output logic [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] f;
  } pifb_flag_st_t;
  pifb_flag_st_t s;
  pifb_flag_st_t next_s;
  // write first, then set on top so an event never loses to a clear
  always_comb begin
    next_s = s;
    if (wr_en) next_s.f = wr_data;
    next_s.f = ((next_s.f | set) & WR_MASK) | (ro_level & RO_MASK);
  end
  // flags clear on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) s.f <= W'(`PIFB_RST_FLAGS);
    else s <= next_s;
  end
  assign flags = s.f;
endmodule : pifb_flag_reg

//--- verification/pifb_periph_model.sv
// peripheral-side model: event strobes, unit output levels, serial buffer levels
`timescale 1ns/10ps
module pifb_periph_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [27:0] fire, // one-cycle event requests
  input wire logic [2:0] lvl, // unit b/a outputs, gate level
  input wire logic [3:0] ser, // rx arrive, rx read, tx sent, tx load
  output logic [27:0] evt,
  output logic [1:0] cc_out,
  output logic gate,
  output logic rx_lvl,
  output logic tx_lvl
);
  // events are single-cycle strobes, so they pass straight through
  assign evt = fire;
  assign cc_out = lvl[1:0];
  assign gate = lvl[2];
  // ----------------------------------------
  // serial buffer levels
  // ----------------------------------------
  // the levels drop only on buffer access or reset, never on a flag write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_lvl <= 1'b0;
      tx_lvl <= 1'b0;
    end else begin
      if (ser[0]) rx_lvl <= 1'b1;
      if (ser[1]) rx_lvl <= 1'b0;
      if (ser[2]) tx_lvl <= 1'b1;
      if (ser[3]) tx_lvl <= 1'b0;
    end
  end
endmodule : pifb_periph_model

//--- verification/pifb_top_tb.sv
// self-checking bench for the flag bank
`timescale 1ns/10ps
`include "pifb_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module pifb_top_tb;
  typedef struct packed {logic [4:0] k; logic [7:0] idx; logic [7:0] exp;} pifb_row_t;
  localparam logic [7:0] SY = `PIFB_IDX_SYS;
  localparam logic [7:0] TC = `PIFB_IDX_TC;
  localparam logic [7:0] PW = `PIFB_IDX_PW;
  localparam logic [7:0] SL = `PIFB_IDX_SL;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata;
  logic [7:0] last_q;
  logic [27:0] fire = '0, evt;
  logic [2:0] lvl = '0;
  logic [3:0] ser = '0;
  logic [1:0] cc_out;
  logic gate, rx_lvl, tx_lvl;
  int miscompares = 0;
  int n_checks = 0;
  // one event per row, flag position as the register shows it
  pifb_row_t rows [20] = '{
    '{5'd0, SY, 8'h20}, '{5'd1, SY, 8'h10}, '{5'd2, SY, 8'h08},
    '{5'd3, SY, 8'h04}, '{5'd4, SY, 8'h02}, '{5'd5, SY, 8'h01},
    '{5'd10, TC, 8'h04}, '{5'd11, TC, 8'h08}, '{5'd12, TC, 8'h10},
    '{5'd13, TC, 8'h01}, '{5'd14, PW, 8'h02}, '{5'd15, PW, 8'h08},
    '{5'd16, PW, 8'h20}, '{5'd17, PW, 8'h80}, '{5'd18, PW, 8'h01},
    '{5'd19, PW, 8'h04}, '{5'd20, PW, 8'h10}, '{5'd21, PW, 8'h40},
    '{5'd22, SL, 8'h01}, '{5'd27, SL, 8'h20}};
  always #12.5 aclk = ~aclk;
  pifb_top #(.ADDR_W(12)) DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .osc_fail_evt(evt[0]), .clock_switch_evt(evt[1]),
    .clock_tuning_evt(evt[2]), .mem_scanner_evt(evt[3]), .checksum_evt(evt[4]),
    .nonvol_op_done_evt(evt[5]), .capcmp_capture(evt[7:6]), .capcmp_match(evt[9:8]),
    .capcmp_out(cc_out), .period_timer_evt(evt[12:10]), .gated_timer_b_evt(evt[13]),
    .gated_timer_b_gate(gate), .pulse_param_evt(evt[17:14]),
    .pulse_period_evt(evt[21:18]), .logic_cell_evt(evt[27:22]),
    .serial_a_rx_flag(rx_lvl), .serial_a_tx_flag(tx_lvl));
  pifb_periph_model peers (.aclk, .aresetn, .fire, .lvl, .ser, .evt, .cc_out, .gate,
    .rx_lvl, .tx_lvl);
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // one transfer; each channel is released at its own handshake edge
  task automatic xfer(input logic is_wr, input logic [7:0] i, input logic [7:0] d);
    int n;
    logic a, w, r, done;
    @(posedge aclk);
    if (is_wr) begin
      awaddr <= {2'b00, i, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= {2'b00, i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    done = 1'b0;
    for (n = 0; !done; n++) begin
      if (n == 50) begin
        miscompares++;
        print_verdict();
      end
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      r = arvalid && arready;
      done = (bvalid && bready) || (rvalid && rready);
      last_q = rdata[7:0];
      last_resp = is_wr ? bresp : rresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (r) arvalid <= 1'b0;
      if (done) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
  endtask : xfer
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    `CHK("rdata", e, last_q)
  endtask : rc
  // strobe events and serial commands for a single cycle
  task automatic strobe(input logic [27:0] f, input logic [3:0] s);
    fire <= f;
    ser <= s;
    @(posedge aclk);
    fire <= '0;
    ser <= '0;
  endtask : strobe
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[j]) rc(rows[j].idx, 8'h00);
    foreach (rows[j]) begin
      strobe(28'h1 << rows[j].k, 4'h0);
      rc(rows[j].idx, rows[j].exp);
      xfer(1'b1, rows[j].idx, 8'h00);
      rc(rows[j].idx, 8'h00);
    end
    xfer(1'b0, 8'h91, 8'h00);
    `CHK("rresp", `PIFB_RESP_SLVERR, last_resp)
    `CHK("rdata", 8'h00, last_q)
    xfer(1'b1, 8'h91, 8'hff);
    `CHK("bresp", `PIFB_RESP_SLVERR, last_resp)
    xfer(1'b1, TC, 8'hff);
    rc(TC, 8'h7f);
    xfer(1'b1, TC, 8'h00);
    strobe(28'h40, 4'h0);
    rc(TC, 8'h00);
    xfer(1'b1, `PIFB_IDX_CTRL, 8'h01);
    strobe(28'h40, 4'h0);
    rc(TC, 8'h20);
    xfer(1'b1, TC, 8'h00);
    xfer(1'b1, `PIFB_IDX_CTRL, 8'h08);
    strobe(28'h200, 4'h0);
    rc(TC, 8'h40);
    xfer(1'b1, TC, 8'h00);
    xfer(1'b1, `PIFB_IDX_CTRL, 8'h03);
    lvl <= 3'h1;
    rc(TC, 8'h00);
    lvl <= 3'h4;
    rc(TC, 8'h20);
    lvl <= 3'h0;
    rc(TC, 8'h22);
    // event held across the whole clearing write: the set must win
    fire <= 28'h2000;
    xfer(1'b1, TC, 8'h00);
    fire <= '0;
    `CHK("bresp", `PIFB_RESP_OKAY, last_resp)
    rc(TC, 8'h01);
    strobe(28'h0, 4'h1);
    xfer(1'b1, SL, 8'h00);
    rc(SL, 8'h80);
    strobe(28'h0, 4'h6);
    rc(SL, 8'h40);
    strobe(28'h0, 4'h8);
    rc(SL, 8'h00);
    // mid-run reset with every event line strobed and both levels raised
    strobe(28'hfffffff, 4'h5);
    rc(SY, 8'h3f);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(SY, 8'h00);
    rc(TC, 8'h00);
    rc(PW, 8'h00);
    rc(SL, 8'h00);
    rc(`PIFB_IDX_CTRL, 8'h00);
    print_verdict();
  end
endmodule : pifb_top_tb
